// ===== include/clock_timer_consts.svh
/*
  Register indices, field positions, reset values and timing figures of the calendar
  clock timer. Assumes it is included by bare name wherever these values are needed.
*/
`ifndef CLOCK_TIMER_CONSTS_SVH
`define CLOCK_TIMER_CONSTS_SVH

`define IDX_W 22
`define IDX_RUN_RESET 22'h040151
`define IDX_INT_CTRL 22'h040152
`define IDX_DIVIDER 22'h040153
`define IDX_SECONDS 22'h040154
`define IDX_MINUTES 22'h040155
`define IDX_HOURS 22'h040156
`define IDX_DAYS_LO 22'h040157
`define IDX_DAYS_HI 22'h040158
`define IDX_MIN_CMP 22'h040159
`define IDX_HOUR_CMP 22'h04015a
`define IDX_DAY_CMP 22'h04015b
`define IDX_OSC_CTRL 22'h04015f
`define IDX_IRQ_LEVEL 22'h040265
`define IDX_IRQ_ENABLE 22'h040277
`define IDX_IRQ_FLAGS 22'h040287
`define IDX_FLAG_MODE 22'h040297

`define BIT_RUN 0
`define BIT_CLEAR 1
`define BIT_PER_FLAG 1
`define BIT_ALM_FLAG 0
`define PER_SEL_HI 7
`define PER_SEL_LO 5
`define ALM_SEL_DAY 4
`define ALM_SEL_HOUR 3
`define ALM_SEL_MIN 2
`define BIT_AUTO_OFF 7
`define BIT_ISOLATE 2
`define BIT_OSC_RSVD 0
`define BIT_IRQ_EN 1
`define BIT_IRQ_PEND 1
`define BIT_CLEAR_ONLY 0

`define SEC_MAX 6'h3b
`define MIN_MAX 6'h3b
`define HOUR_MAX 6'h17
`define DIV_MAX 8'hff

`define AUTO_OFF_RST 1'b0
`define ISOLATE_RST 1'b0
`define IRQ_EN_RST 1'b0
`define CLEAR_ONLY_RST 1'b1

`define CLK_PERIOD_NS 25
`define TICK_PERIOD_NS 3906250

`endif

// ===== include/clock_timer_pkg.sv
/*
  Types shared by the calendar clock timer modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package clock_timer_pkg;

  typedef enum logic [2:0] {
    PER_32HZ = 3'b000,
    PER_8HZ = 3'b001,
    PER_2HZ = 3'b010,
    PER_1HZ = 3'b011,
    PER_MINUTE = 3'b100,
    PER_HOUR = 3'b101,
    PER_DAY = 3'b110,
    PER_NONE = 3'b111
  } periodic_sel_e;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_e;

endpackage

// ===== include/reg_access_if.sv
/*
  Byte register access between the bus slave and the timer register file.
  Assumes the bridge raises wrEn or rdEn for one cycle and samples the answer then.
*/
`include "clock_timer_consts.svh"

interface reg_access_if;
  logic wrEn;
  logic wrByteEn;
  logic [`IDX_W-1:0] wrIdx;
  logic [7:0] wrData;
  logic wrHit;
  logic rdEn;
  logic [`IDX_W-1:0] rdIdx;
  logic [7:0] rdData;
  logic rdHit;

  modport bridge (
    output wrEn, wrByteEn, wrIdx, wrData, rdEn, rdIdx,
    input wrHit, rdData, rdHit
  );
  modport regs (
    input wrEn, wrByteEn, wrIdx, wrData, rdEn, rdIdx,
    output wrHit, rdData, rdHit
  );
endinterface

// ===== design/tick_divider.sv
/*
  Divides the system clock down to the 256 Hz count enable of the timer.
  Assumes TICK_CYCLES is at least 2 and that clear is a synchronous request.
*/
module tick_divider #(
  parameter int unsigned TICK_CYCLES = 156250
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic clear,
  output logic tick
);
  localparam int CNT_W = $clog2(TICK_CYCLES);

  logic [CNT_W-1:0] count;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      count <= '0;
      tick <= 1'b0;
    end else if (clear) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == CNT_W'(TICK_CYCLES - 1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + CNT_W'(1);
      tick <= 1'b0;
    end
  end
endmodule

// ===== design/axil_byte_slave.sv
/*
  AXI4-Lite slave that turns each word access into one byte register access.
  Assumes byte lane 0 carries the register; the register file answers in the same cycle.
*/
`include "clock_timer_consts.svh"

module axil_byte_slave
  import clock_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic [`IDX_W+1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`IDX_W+1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  reg_access_if.bridge regs
);
  logic awHeld;
  logic wHeld;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awready <= 1'b0;
      wready <= 1'b0;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      regs.wrEn <= 1'b0;
      regs.wrIdx <= '0;
      regs.wrData <= 8'h00;
      regs.wrByteEn <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awready <= 1'b0;
        regs.wrIdx <= awaddr[`IDX_W+1:2];
      end else if (!awHeld && !bvalid && !regs.wrEn) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wready <= 1'b0;
        regs.wrData <= wdata[7:0];
        regs.wrByteEn <= wstrb[0];
      end else if (!wHeld && !bvalid && !regs.wrEn) begin
        wready <= 1'b1;
      end
      if (awHeld && wHeld && !regs.wrEn && !bvalid) begin
        regs.wrEn <= 1'b1;
      end
      if (regs.wrEn) begin
        regs.wrEn <= 1'b0;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= regs.wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      regs.rdEn <= 1'b0;
      regs.rdIdx <= '0;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        regs.rdEn <= 1'b1;
        regs.rdIdx <= araddr[`IDX_W+1:2];
      end else if (!rvalid && !regs.rdEn) begin
        arready <= 1'b1;
      end
      if (regs.rdEn) begin
        regs.rdEn <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h000000, regs.rdData};
        rresp <= regs.rdHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== design/calendar_clock_timer_alarm.sv
/*
  Calendar clock timer: 1-128 Hz divider, second, minute, hour and day counters,
  periodic and alarm factors, auto-off, power isolation and the interrupt request logic.
  Assumes a 40 MHz clock, AXI4-Lite software access and synchronous pin inputs.
*/
`include "clock_timer_consts.svh"

// What this block does
// - A one written to the clear bit while stopped zeroes every counter.
// - Clear is ignored while running, or when the same write starts the timer.
// - Writing zero to the clear bit does nothing; it always reads zero.
// - Reset leaves counters, run state, alarms, selections and factor flags alone.
// - The run bit starts and halts counting; values hold; it reads back.
// - All counters read; minute, hour, day write; divider and seconds ignore writes.
// - Divider eight bits, seconds and minutes six, hours five, days sixteen.
// - Unused upper bits of seconds, minutes and hours read zero.
// - Selected compare values match counters; day uses five low bits; all readable.
// - With auto-off set an alarm stops oscillator and timer; reset clears it.
// - Isolation makes timer and oscillator ignore system supply controls.
// - Periodic select picks none, day, hour, minute, 1, 2, 8 or 32 Hz falling edge.
// - Alarm select bits day, hour, minute combine; all selected must match.
// - Periodic flag sets on its factor, clears only by writing one.
// - Alarm flag sets when all selected alarms match, clears only by writing one.
// - Interrupt level field holds 0 to 7 and is undefined after reset.
// - Interrupt enable gates requests, reads back and resets to zero.
// - Pending flag sets on any selected factor regardless of enable or level.
// - Request needs pending, enable, no higher request, CPU enable, level above CPU.
// - Clear-only mode: one clears pending; read/write mode: written value is stored.
module calendar_clock_timer_alarm
  import clock_timer_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [`IDX_W+1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`IDX_W+1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic systemStopRequest,
  input wire logic higherIrqPending,
  input wire logic processor_irq_enable,
  input wire logic [2:0] processor_irq_level,
  output logic slowOscillatorEnable,
  output logic corePowerIsolated,
  output logic timerIrqRequest
);
  logic rstMeta;
  logic rstN;
  logic tick;
  logic clearCounters;
  logic wrOk;

  // Software-visible state; most of it deliberately has no reset.
  logic timer_run_control;
  logic [7:0] subsecond_divider_value;
  logic [5:0] seconds_value;
  logic [5:0] minutes_value;
  logic [4:0] hours_value;
  logic [15:0] days_value;
  logic [5:0] minute_alarm_value;
  logic [4:0] hour_alarm_value;
  logic [4:0] day_alarm_value;
  periodic_sel_e periodic_source_select;
  logic [2:0] alarm_source_select;
  logic periodic_event_flag;
  logic alarm_event_flag;
  logic [2:0] timer_irq_level;
  logic timer_irq_pending;
  logic timer_irq_enable;
  logic alarm_auto_stop_enable;
  logic core_power_isolation;
  logic flag_clear_only_mode;
  logic autoStopped;
  logic prevMatch;

  logic advance;
  logic [7:0] next_divider;
  logic [7:0] dividerFall;
  logic secondCarry;
  logic minuteCarry;
  logic hourCarry;
  logic dayCarry;
  logic periodicEvent;
  logic alarmMatch;
  logic alarmEvent;

  reg_access_if regBus ();

  function automatic logic [5:0] wrapInc(input logic [5:0] value, input logic [5:0] top);
    wrapInc = (value == top) ? 6'h00 : value + 6'h01;
  endfunction

  function automatic logic isMapped(input logic [`IDX_W-1:0] idx);
    logic low;
    low = (idx >= `IDX_RUN_RESET) && (idx <= `IDX_DAY_CMP);
    isMapped = low || idx == `IDX_OSC_CTRL || idx == `IDX_IRQ_LEVEL ||
      idx == `IDX_IRQ_ENABLE || idx == `IDX_IRQ_FLAGS || idx == `IDX_FLAG_MODE;
  endfunction

  // The external reset is released through two flip-flops before anything uses it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  axil_byte_slave bridge (
    .clk(clk),
    .rstN(rstN),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .regs(regBus.bridge)
  );

  tick_divider #(
    .TICK_CYCLES(TICK_CYCLES)
  ) tickGen (
    .clk(clk),
    .rstN(rstN),
    .clear(clearCounters),
    .tick(tick)
  );

  assign wrOk = regBus.wrEn && regBus.wrByteEn;
  assign regBus.wrHit = isMapped(regBus.wrIdx);
  assign regBus.rdHit = isMapped(regBus.rdIdx);

  // The same write that sets run cannot also clear.
  assign clearCounters = wrOk && regBus.wrIdx == `IDX_RUN_RESET && !timer_run_control &&
    regBus.wrData[`BIT_CLEAR] && !regBus.wrData[`BIT_RUN];

  // Counting needs the run bit and a running oscillator.
  assign advance = tick && timer_run_control && slowOscillatorEnable;
  assign next_divider = subsecond_divider_value + 8'h01;
  assign dividerFall = subsecond_divider_value & ~next_divider;
  assign secondCarry = advance && subsecond_divider_value == `DIV_MAX;
  assign minuteCarry = secondCarry && seconds_value == `SEC_MAX;
  assign hourCarry = minuteCarry && minutes_value == `MIN_MAX;
  assign dayCarry = hourCarry && {1'b0, hours_value} == `HOUR_MAX;

  always_comb begin
    periodicEvent = 1'b0;
    case (periodic_source_select)
      PER_32HZ: periodicEvent = advance && dividerFall[2];
      PER_8HZ: periodicEvent = advance && dividerFall[4];
      PER_2HZ: periodicEvent = advance && dividerFall[6];
      PER_1HZ: periodicEvent = advance && dividerFall[7];
      PER_MINUTE: periodicEvent = minuteCarry;
      PER_HOUR: periodicEvent = hourCarry;
      PER_DAY: periodicEvent = dayCarry;
      default: periodicEvent = 1'b0;
    endcase
  end

  // Only the selected comparisons take part, and at least one must be selected.
  assign alarmMatch = (|alarm_source_select) &&
    (!alarm_source_select[2] || days_value[4:0] == day_alarm_value) &&
    (!alarm_source_select[1] || hours_value == hour_alarm_value) &&
    (!alarm_source_select[0] || minutes_value == minute_alarm_value);
  assign alarmEvent = alarmMatch && !prevMatch;

  // Counters: no reset on purpose, so a chip reset leaves the time intact.
  always_ff @(posedge clk) begin
    if (clearCounters) begin
      subsecond_divider_value <= 8'h00;
      seconds_value <= 6'h00;
      minutes_value <= 6'h00;
      hours_value <= 5'h00;
      days_value <= 16'h0000;
    end else begin
      if (advance) begin
        subsecond_divider_value <= next_divider;
      end
      if (secondCarry) begin
        seconds_value <= wrapInc(seconds_value, `SEC_MAX);
      end
      if (wrOk && regBus.wrIdx == `IDX_MINUTES) begin
        minutes_value <= regBus.wrData[5:0];
      end else if (minuteCarry) begin
        minutes_value <= wrapInc(minutes_value, `MIN_MAX);
      end
      if (wrOk && regBus.wrIdx == `IDX_HOURS) begin
        hours_value <= regBus.wrData[4:0];
      end else if (hourCarry) begin
        hours_value <= 5'(wrapInc({1'b0, hours_value}, `HOUR_MAX));
      end
      if (wrOk && regBus.wrIdx == `IDX_DAYS_LO) begin
        days_value[7:0] <= regBus.wrData;
      end else if (wrOk && regBus.wrIdx == `IDX_DAYS_HI) begin
        days_value[15:8] <= regBus.wrData;
      end else if (dayCarry) begin
        days_value <= days_value + 16'h0001;
      end
    end
  end

  // Settings (run bit, compare values, selections, level) that survive a chip reset.
  always_ff @(posedge clk) begin
    if (wrOk && regBus.wrIdx == `IDX_RUN_RESET) begin
      timer_run_control <= regBus.wrData[`BIT_RUN];
    end
    if (wrOk && regBus.wrIdx == `IDX_MIN_CMP) begin
      minute_alarm_value <= regBus.wrData[5:0];
    end
    if (wrOk && regBus.wrIdx == `IDX_HOUR_CMP) begin
      hour_alarm_value <= regBus.wrData[4:0];
    end
    if (wrOk && regBus.wrIdx == `IDX_DAY_CMP) begin
      day_alarm_value <= regBus.wrData[4:0];
    end
    if (wrOk && regBus.wrIdx == `IDX_INT_CTRL) begin
      periodic_source_select <= periodic_sel_e'(regBus.wrData[`PER_SEL_HI:`PER_SEL_LO]);
      alarm_source_select <= regBus.wrData[`ALM_SEL_DAY:`ALM_SEL_MIN];
    end
    if (wrOk && regBus.wrIdx == `IDX_IRQ_LEVEL) begin
      timer_irq_level <= regBus.wrData[2:0];
    end
  end

  // A factor arriving with the clearing write still sets its flag.
  always_ff @(posedge clk) begin
    if (periodicEvent) begin
      periodic_event_flag <= 1'b1;
    end else if (wrOk && regBus.wrIdx == `IDX_INT_CTRL && regBus.wrData[`BIT_PER_FLAG]) begin
      periodic_event_flag <= 1'b0;
    end
    if (alarmEvent) begin
      alarm_event_flag <= 1'b1;
    end else if (wrOk && regBus.wrIdx == `IDX_INT_CTRL && regBus.wrData[`BIT_ALM_FLAG]) begin
      alarm_event_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (periodicEvent || alarmEvent) begin
      timer_irq_pending <= 1'b1;
    end else if (wrOk && regBus.wrIdx == `IDX_IRQ_FLAGS) begin
      if (!flag_clear_only_mode) begin
        timer_irq_pending <= regBus.wrData[`BIT_IRQ_PEND];
      end else if (regBus.wrData[`BIT_IRQ_PEND]) begin
        timer_irq_pending <= 1'b0;
      end
    end
  end

  // The previous match is preset at reset so a standing match raises no alarm.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prevMatch <= 1'b1;
    end else begin
      prevMatch <= alarmMatch;
    end
  end

  // Control bits that do have a defined reset value.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      alarm_auto_stop_enable <= `AUTO_OFF_RST;
      core_power_isolation <= `ISOLATE_RST;
      timer_irq_enable <= `IRQ_EN_RST;
      flag_clear_only_mode <= `CLEAR_ONLY_RST;
    end else if (wrOk) begin
      if (regBus.wrIdx == `IDX_OSC_CTRL) begin
        alarm_auto_stop_enable <= regBus.wrData[`BIT_AUTO_OFF];
        core_power_isolation <= regBus.wrData[`BIT_ISOLATE];
      end
      if (regBus.wrIdx == `IDX_IRQ_ENABLE) begin
        timer_irq_enable <= regBus.wrData[`BIT_IRQ_EN];
      end
      if (regBus.wrIdx == `IDX_FLAG_MODE) begin
        flag_clear_only_mode <= regBus.wrData[`BIT_CLEAR_ONLY];
      end
    end
  end

  // Once auto-off has fired, only disabling auto-off or a reset lets the oscillator run.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      autoStopped <= 1'b0;
    end else if (alarmEvent && alarm_auto_stop_enable) begin
      autoStopped <= 1'b1;
    end else if (!alarm_auto_stop_enable) begin
      autoStopped <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      slowOscillatorEnable <= 1'b1;
      corePowerIsolated <= 1'b0;
    end else begin
      slowOscillatorEnable <= !(autoStopped ||
        (systemStopRequest && !core_power_isolation));
      corePowerIsolated <= core_power_isolation;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      timerIrqRequest <= 1'b0;
    end else begin
      timerIrqRequest <= timer_irq_pending && timer_irq_enable && !higherIrqPending &&
        processor_irq_enable && (timer_irq_level > processor_irq_level);
    end
  end

  // Read mux: unused upper bits and the write-only clear bit read as zero.
  always_comb begin
    regBus.rdData = 8'h00;
    if (regBus.rdIdx == `IDX_RUN_RESET) begin
      regBus.rdData = {7'h00, timer_run_control};
    end else if (regBus.rdIdx == `IDX_INT_CTRL) begin
      regBus.rdData = {periodic_source_select, alarm_source_select,
        periodic_event_flag, alarm_event_flag};
    end else if (regBus.rdIdx == `IDX_DIVIDER) begin
      regBus.rdData = subsecond_divider_value;
    end else if (regBus.rdIdx == `IDX_SECONDS) begin
      regBus.rdData = {2'h0, seconds_value};
    end else if (regBus.rdIdx == `IDX_MINUTES) begin
      regBus.rdData = {2'h0, minutes_value};
    end else if (regBus.rdIdx == `IDX_HOURS) begin
      regBus.rdData = {3'h0, hours_value};
    end else if (regBus.rdIdx == `IDX_DAYS_LO) begin
      regBus.rdData = days_value[7:0];
    end else if (regBus.rdIdx == `IDX_DAYS_HI) begin
      regBus.rdData = days_value[15:8];
    end else if (regBus.rdIdx == `IDX_MIN_CMP) begin
      regBus.rdData = {2'h0, minute_alarm_value};
    end else if (regBus.rdIdx == `IDX_HOUR_CMP) begin
      regBus.rdData = {3'h0, hour_alarm_value};
    end else if (regBus.rdIdx == `IDX_DAY_CMP) begin
      regBus.rdData = {3'h0, day_alarm_value};
    end else if (regBus.rdIdx == `IDX_OSC_CTRL) begin
      regBus.rdData[`BIT_AUTO_OFF] = alarm_auto_stop_enable;
      regBus.rdData[`BIT_ISOLATE] = core_power_isolation;
      regBus.rdData[`BIT_OSC_RSVD] = 1'b1;
    end else if (regBus.rdIdx == `IDX_IRQ_LEVEL) begin
      regBus.rdData = {5'h00, timer_irq_level};
    end else if (regBus.rdIdx == `IDX_IRQ_ENABLE) begin
      regBus.rdData[`BIT_IRQ_EN] = timer_irq_enable;
    end else if (regBus.rdIdx == `IDX_IRQ_FLAGS) begin
      regBus.rdData[`BIT_IRQ_PEND] = timer_irq_pending;
    end else if (regBus.rdIdx == `IDX_FLAG_MODE) begin
      regBus.rdData[`BIT_CLEAR_ONLY] = flag_clear_only_mode;
    end
  end
endmodule

// ===== tb/calendar_clock_timer_alarm_asserts.sv
/*
  Port-level assertions for the calendar clock timer top module.
  Assumes one clock domain and the bind statement at the foot of this file.
*/
module calendar_clock_timer_alarm_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic systemStopRequest,
  input wire logic higherIrqPending,
  input wire logic processor_irq_enable,
  input wire logic slowOscillatorEnable,
  input wire logic corePowerIsolated,
  input wire logic timerIrqRequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence stopAsked;
    (systemStopRequest && !corePowerIsolated) [*2];
  endsequence
  a_write_answer: assert property (wrTaken |-> ##3 bvalid) else $error("late write answer");
  a_read_answer: assert property (arvalid && arready |-> ##2 rvalid)
    else $error("late read answer");
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer changed");
  a_aw_refused: assert property (bvalid && bready |=> !awready) else $error("early awready");
  a_rdata_byte: assert property (rvalid |-> rdata[31:8] == 24'h0) else $error("upper data set");
  a_slverr_zero: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
    else $error("error read carries data");
  a_irq_gate: assert property (timerIrqRequest |->
    $past(processor_irq_enable) && !$past(higherIrqPending))
    else $error("request while blocked");
  a_stop_honoured: assert property (stopAsked |-> ##[0:2] !slowOscillatorEnable)
    else $error("stop request ignored");
endmodule

bind calendar_clock_timer_alarm calendar_clock_timer_alarm_asserts chk (.clk, .arst_n,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp,
  .rvalid, .rready, .systemStopRequest, .higherIrqPending, .processor_irq_enable,
  .slowOscillatorEnable, .corePowerIsolated, .timerIrqRequest);

// ===== tb/calendar_clock_timer_alarm_tb.sv
/*
  Self-checking bench for the calendar clock timer over its AXI4-Lite port.
  Assumes the design, its package and its interface are compiled first.
*/
`include "clock_timer_consts.svh"

module calendar_clock_timer_alarm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, systemStopRequest = 1'b0, higherIrqPending = 1'b0;
  logic processor_irq_enable = 1'b1;
  logic [2:0] processor_irq_level = 3'h2;
  logic [23:0] awaddr = 24'h0, araddr = 24'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, rdResp, wrResp;
  logic awready, wready, bvalid, arready, rvalid;
  logic slowOscillatorEnable, corePowerIsolated, timerIrqRequest;
  logic [7:0] rdByte;
  int n_fail = 0, num_checks = 0, cycles = 0;

  calendar_clock_timer_alarm #(.TICK_CYCLES(4)) dut (.*);

  initial forever #12.5 clk = ~clk;

  // The slowest scenario waits at most about 1700 cycles for four periodic events.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      results();
    end
  end

  task automatic results;
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [21:0] idx, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin do @(posedge clk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge clk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    while (bvalid !== 1'b1) @(posedge clk);
    wrResp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [21:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rdByte = rdata[7:0];
    rdResp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [21:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(rdByte, exp);
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (timerIrqRequest !== lvl && n < 1500) begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, timerIrqRequest}, {7'h0, lvl});
  endtask

  task automatic t_regs;
    logic [21:0] ix [9] = '{`IDX_DIVIDER, `IDX_SECONDS, `IDX_MINUTES, `IDX_HOURS,
      `IDX_DAYS_LO, `IDX_DAYS_HI, `IDX_MIN_CMP, `IDX_HOUR_CMP, `IDX_DAY_CMP};
    logic [7:0] ex [9] = '{8'h00, 8'h00, 8'h3f, 8'h1f, 8'ha5, 8'h5a, 8'h3f, 8'h1f, 8'h1f};
    wr(`IDX_RUN_RESET, 8'h00);
    wr(`IDX_RUN_RESET, 8'h02);
    for (int i = 0; i < 9; i++) begin
      wr(ix[i], (i == 4 || i == 5) ? ex[i] : 8'hff);
      rc(ix[i], ex[i]);
    end
    wr(`IDX_RUN_RESET, 8'h02);
    for (int i = 0; i < 6; i++) rc(ix[i], 8'h00);
    rc(`IDX_RUN_RESET, 8'h00);
    rd(22'h040150);
    wr(22'h040150, 8'h00);
    chk({4'h0, wrResp, rdResp}, 8'h0a);
  endtask

  task automatic t_count;
    wr(`IDX_MINUTES, 8'h05);
    wr(`IDX_RUN_RESET, 8'h03);
    rc(`IDX_RUN_RESET, 8'h01);
    repeat (1100) @(posedge clk);
    wr(`IDX_RUN_RESET, 8'h03);
    wr(`IDX_RUN_RESET, 8'h00);
    rc(`IDX_SECONDS, 8'h01);
    rc(`IDX_MINUTES, 8'h05);
    rd(`IDX_DIVIDER);
    repeat (40) @(posedge clk);
    rc(`IDX_DIVIDER, rdByte);
  endtask

  task automatic t_periodic;
    wr(`IDX_IRQ_LEVEL, 8'h05);
    wr(`IDX_IRQ_ENABLE, 8'h02);
    wr(`IDX_RUN_RESET, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(`IDX_INT_CTRL, {s[2:0], 5'h03});
      wr(`IDX_IRQ_FLAGS, 8'h02);
      wait_irq(1'b1);
      rc(`IDX_INT_CTRL, {s[2:0], 5'h02});
    end
    wr(`IDX_IRQ_FLAGS, 8'h00);
    rc(`IDX_IRQ_FLAGS, 8'h02);
    higherIrqPending <= 1'b1;
    wait_irq(1'b0);
    higherIrqPending <= 1'b0;
    processor_irq_level <= 3'h5;
    wait_irq(1'b0);
    processor_irq_level <= 3'h2;
    wr(`IDX_IRQ_ENABLE, 8'h00);
    wait_irq(1'b0);
    wr(`IDX_INT_CTRL, 8'he3);
    repeat (300) @(posedge clk);
    rc(`IDX_INT_CTRL, 8'he0);
    wr(`IDX_RUN_RESET, 8'h00);
    wr(`IDX_FLAG_MODE, 8'h00);
    wr(`IDX_IRQ_FLAGS, 8'h02);
    rc(`IDX_IRQ_FLAGS, 8'h02);
    wr(`IDX_IRQ_FLAGS, 8'h00);
    rc(`IDX_IRQ_FLAGS, 8'h00);
    wr(`IDX_FLAG_MODE, 8'h01);
  endtask

  // A stopped timer still compares, so a counter write can make the match edge.
  task automatic t_alarm;
    wr(`IDX_MIN_CMP, 8'h09);
    wr(`IDX_MINUTES, 8'h03);
    wr(`IDX_INT_CTRL, 8'he7);
    wr(`IDX_OSC_CTRL, 8'h81);
    wr(`IDX_MINUTES, 8'h09);
    rc(`IDX_INT_CTRL, 8'he5);
    chk({7'h0, slowOscillatorEnable}, 8'h00);
    wr(`IDX_OSC_CTRL, 8'h01);
    rc(`IDX_OSC_CTRL, 8'h01);
    chk({7'h0, slowOscillatorEnable}, 8'h01);
    wr(`IDX_INT_CTRL, 8'hf7);
    wr(`IDX_DAY_CMP, 8'h03);
    wr(`IDX_DAYS_LO, 8'h20);
    wr(`IDX_MINUTES, 8'h08);
    wr(`IDX_MINUTES, 8'h09);
    rc(`IDX_INT_CTRL, 8'hf4);
    wr(`IDX_DAYS_LO, 8'h23);
    rc(`IDX_INT_CTRL, 8'hf5);
    chk({7'h0, slowOscillatorEnable}, 8'h01);
  endtask

  task automatic t_power;
    systemStopRequest <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h0, slowOscillatorEnable}, 8'h00);
    wr(`IDX_OSC_CTRL, 8'h05);
    rc(`IDX_OSC_CTRL, 8'h05);
    chk({6'h0, corePowerIsolated, slowOscillatorEnable}, 8'h03);
    systemStopRequest <= 1'b0;
    wr(`IDX_MINUTES, 8'h11);
    wr(`IDX_OSC_CTRL, 8'h85);
    wr(`IDX_IRQ_ENABLE, 8'h02);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rc(`IDX_MINUTES, 8'h11);
    rc(`IDX_OSC_CTRL, 8'h01);
    rc(`IDX_IRQ_ENABLE, 8'h00);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_count();
    t_periodic();
    t_alarm();
    t_power();
    results();
  end
endmodule
